// ---- rtl/sif_indexer.v ----
// Stepper indexer: standby, fault latch, angle stepping, phase ratios, monitors
//
// Operation
// - All three step-select bits low means standby; any other code is normal operation.
// - In standby the bias enable is dropped to put internal circuits in low power.
// - Entering standby clears any held thermal or overcurrent fault.
// - A latched fault is released when the controller cycles standby off and on again.
// - A fresh motor supply power-up clears the latched fault like a standby cycle.
// - Phase currents come from a 33-entry ratio table indexed by angle step 0 to 32.
// - In half step variant a the 71 percent position drives 100 percent instead.
// - In quarter step the substitution position drives 100 percent instead.
// - The home monitor pulls low at the initial angle and floats at any other angle.
// - The fault monitor floats normally and pulls low from fault detection until release.
// - Step-select decodes standby, full, half a, quarter, half b, 1/8, 1/16, 1/32.
// - Each step clock rising edge after the startup quiet period, with the reset pin low, advances the angle one step; falling edges do nothing.
// - A high reset pin holds the angle at the initial 45 degree position.
// - Direction high lets phase A lead B by 90 degrees; low lets B lead A.
`timescale 1ns/1ps
`include "sif_regs.vh"
module sif_indexer #(
  parameter STARTUP_CYC = `SIF_STARTUP_CYC
) (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       step_clk_i,
  input  wire       direction_select_i,
  input  wire       angle_reset_i,
  input  wire       step_select_bit0_i,
  input  wire       step_select_bit1_i,
  input  wire       step_select_bit2_i,
  input  wire       thermal_shutdown_fault_i,
  input  wire       overcurrent_fault_i,
  input  wire       motor_supply_good_i,
  output reg        bias_enable_o,
  output reg        outputs_enable_o,
  output reg        startup_busy_o,
  output reg  [6:0] ratio_a_o,
  output reg  [6:0] ratio_b_o,
  output reg        sign_a_o,
  output reg        sign_b_o,
  output reg        home_angle_monitor_o,
  output reg        home_angle_monitor_oe_o,
  output reg        fault_monitor_o,
  output reg        fault_monitor_oe_o
);
  // ---------------------------------------------------------------
  // Pin synchronisers: three stages, change taken once 2nd and 3rd agree
  // ---------------------------------------------------------------
  localparam NPIN = 9;
  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin;
  assign pin_raw = {motor_supply_good_i, overcurrent_fault_i, thermal_shutdown_fault_i,
                    step_select_bit2_i, step_select_bit1_i, step_select_bit0_i,
                    angle_reset_i, direction_select_i, step_clk_i};
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_sync
      // Each bit owns its stages, so no vector has more than one driver
      reg s1;
      reg s2;
      reg s3;
      reg held;
      always @(posedge clk_sys_i) begin
        if (rst_i) begin
          s1   <= 1'b0;
          s2   <= 1'b0;
          s3   <= 1'b0;
          held <= 1'b0;
        end else begin
          s1 <= pin_raw[g];
          s2 <= s1;
          s3 <= s2;
          // A one-cycle glitch never makes stages 2 and 3 agree
          if (s2 == s3) begin
            held <= s3;
          end
        end
      end
      assign pin[g] = held;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pin decode
  // ---------------------------------------------------------------
  wire       clk_lvl     = pin[0];
  wire       dir         = pin[1];
  wire       ang_rst     = pin[2];
  // Bit0 is the code MSB, so selector reads {bit0, bit1, bit2}
  wire [2:0] sel         = {pin[3], pin[4], pin[5]};
  wire       thermal_flt = pin[6];
  wire       overcur_flt = pin[7];
  wire       supply_good = pin[8];

  // ---------------------------------------------------------------
  // Standby, startup quiet period, fault latch
  // ---------------------------------------------------------------
  localparam CNT_W = 16;
  reg              clk_prev;
  reg              supply_prev;
  reg              fault;
  reg  [CNT_W-1:0] quiet_cnt;
  reg  [6:0]       angle;
  wire             standby     = (sel == `SIF_SEL_STANDBY);
  wire             supply_rise = supply_good & ~supply_prev;
  wire             run         = ~standby & (quiet_cnt == {CNT_W{1'b0}});

  // Quiet period counter
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      quiet_cnt <= {CNT_W{1'b0}};
    end else begin
      if (standby) begin
        // Step clock edges are ignored until the quiet period ends, so arm it here
        quiet_cnt <= STARTUP_CYC[CNT_W-1:0];
      end else if (quiet_cnt != {CNT_W{1'b0}}) begin
        quiet_cnt <= quiet_cnt - 1'b1;
      end
    end
  end

  // Fault latch: a clear wins over a fault seen in the same cycle
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      supply_prev <= 1'b0;
      fault       <= 1'b0;
    end else begin
      supply_prev <= supply_good;
      if (standby || supply_rise || !supply_good) begin
        fault <= 1'b0;
      end else if (thermal_flt || overcur_flt) begin
        fault <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Electrical angle: 128 positions of 1/32 step, init at entry 16
  // ---------------------------------------------------------------
  reg [6:0] stride;
  always @* begin
    case (sel)
      `SIF_SEL_FULL:    stride = 7'h20;
      `SIF_SEL_HALF_A:  stride = 7'h10;
      `SIF_SEL_HALF_B:  stride = 7'h10;
      `SIF_SEL_QUARTER: stride = 7'h08;
      `SIF_SEL_EIGHTH:  stride = 7'h04;
      `SIF_SEL_SIXTEEN: stride = 7'h02;
      `SIF_SEL_THIRTY2: stride = 7'h01;
      default:          stride = 7'h00;
    endcase
  end

  reg  [6:0] next_angle;
  wire       step_rise = run & clk_lvl & ~clk_prev;

  always @* begin
    next_angle = angle;
    if (ang_rst || standby) begin
      next_angle = `SIF_ANGLE_INIT;
    end else if (step_rise) begin
      // No realignment: changing resolution off its grid keeps the odd angle
      if (dir) begin
        next_angle = angle + stride;
      end else begin
        next_angle = angle - stride;
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      clk_prev <= 1'b0;
      angle    <= `SIF_ANGLE_INIT;
    end else begin
      clk_prev <= clk_lvl;
      angle    <= next_angle;
    end
  end

  // ---------------------------------------------------------------
  // Phase ratios: B uses sin, A uses cos of the same angle
  // ---------------------------------------------------------------
  wire [4:0] quad_pos = angle[4:0];
  wire [1:0] quad     = angle[6:5];
  wire [5:0] idx_b    = quad[0] ? (6'h20 - {1'b0, quad_pos}) : {1'b0, quad_pos};
  wire [5:0] idx_a    = 6'h20 - idx_b;
  wire [6:0] rom_a;
  wire [6:0] rom_b;

  sif_ratio_rom u_rom_a (
    .idx_i   (idx_a),
    .ratio_o (rom_a)
  );
  sif_ratio_rom u_rom_b (
    .idx_i   (idx_b),
    .ratio_o (rom_b)
  );

  function [6:0] fix_ratio;
    input [2:0] s;
    input [5:0] i;
    input [6:0] r;
    begin
      fix_ratio = r;
      if (s == `SIF_SEL_FULL) begin
        fix_ratio = `SIF_RATIO_FULL;
      end else if (s == `SIF_SEL_HALF_A && i == `SIF_IDX_MID) begin
        fix_ratio = `SIF_RATIO_FULL;
      end else if (s == `SIF_SEL_QUARTER && i == `SIF_IDX_Q_SUB) begin
        fix_ratio = `SIF_RATIO_FULL;
      end
    end
  endfunction

  reg [6:0] next_ratio_a;
  reg [6:0] next_ratio_b;

  always @* begin
    next_ratio_a = fix_ratio(sel, idx_a, rom_a);
    next_ratio_b = fix_ratio(sel, idx_b, rom_b);
  end

  // ---------------------------------------------------------------
  // Power state outputs
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      bias_enable_o    <= 1'b0;
      outputs_enable_o <= 1'b0;
      startup_busy_o   <= 1'b0;
    end else begin
      bias_enable_o    <= ~standby;
      outputs_enable_o <= ~standby;
      startup_busy_o   <= ~standby & (quiet_cnt != {CNT_W{1'b0}});
    end
  end

  // ---------------------------------------------------------------
  // Phase ratio and sign outputs
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ratio_a_o <= 7'h00;
      ratio_b_o <= 7'h00;
      sign_a_o  <= 1'b0;
      sign_b_o  <= 1'b0;
    end else begin
      ratio_a_o <= next_ratio_a;
      ratio_b_o <= next_ratio_b;
      // A is cos: negative in quadrants 1 and 2; B is sin: negative in 2 and 3
      sign_a_o  <= quad[1] ^ quad[0];
      sign_b_o  <= quad[1];
    end
  end

  // ---------------------------------------------------------------
  // Open-drain monitors: data held low, enable pulls the pin
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      home_angle_monitor_o    <= 1'b0;
      home_angle_monitor_oe_o <= 1'b0;
      fault_monitor_o         <= 1'b0;
      fault_monitor_oe_o      <= 1'b0;
    end else begin
      home_angle_monitor_o    <= 1'b0;
      home_angle_monitor_oe_o <= (angle == `SIF_ANGLE_INIT);
      fault_monitor_o         <= 1'b0;
      fault_monitor_oe_o      <= fault;
    end
  end
endmodule

// ---- rtl/sif_regs.vh ----
// Constants of the stepper indexer with standby and fault latch
`ifndef SIF_REGS_VH
`define SIF_REGS_VH
// ---------------------------------------------------------------
// Step-select codes
// ---------------------------------------------------------------
`define SIF_SEL_STANDBY  3'h0
`define SIF_SEL_FULL     3'h1
`define SIF_SEL_HALF_A   3'h2
`define SIF_SEL_QUARTER  3'h3
`define SIF_SEL_HALF_B   3'h4
`define SIF_SEL_EIGHTH   3'h5
`define SIF_SEL_SIXTEEN  3'h6
`define SIF_SEL_THIRTY2  3'h7
// ---------------------------------------------------------------
// Angle and table
// ---------------------------------------------------------------
`define SIF_ANGLE_W      7
`define SIF_ANGLE_INIT   7'h10
`define SIF_RATIO_W      7
`define SIF_RATIO_FULL   7'h64
`define SIF_IDX_MID      6'h10
`define SIF_IDX_Q_SUB    6'h18
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SIF_STARTUP_NS   10000
`define SIF_CLK_NS       4
`define SIF_STARTUP_CYC  (`SIF_STARTUP_NS / `SIF_CLK_NS)
`endif

// ---- rtl/sif_ratio_rom.v ----
// Current ratio table, 33 entries, percent
`timescale 1ns/1ps
module sif_ratio_rom (
  input  wire [5:0] idx_i,
  output reg  [6:0] ratio_o
);
  always @* begin
    case (idx_i)
      6'h00: ratio_o = 7'h00;
      6'h01: ratio_o = 7'h05;
      6'h02: ratio_o = 7'h0A;
      6'h03: ratio_o = 7'h0F;
      6'h04: ratio_o = 7'h14;
      6'h05: ratio_o = 7'h19;
      6'h06: ratio_o = 7'h1D;
      6'h07: ratio_o = 7'h22;
      6'h08: ratio_o = 7'h26;
      6'h09: ratio_o = 7'h2B;
      6'h0A: ratio_o = 7'h2F;
      6'h0B: ratio_o = 7'h34;
      6'h0C: ratio_o = 7'h38;
      6'h0D: ratio_o = 7'h3C;
      6'h0E: ratio_o = 7'h3F;
      6'h0F: ratio_o = 7'h43;
      6'h10: ratio_o = 7'h47;
      6'h11: ratio_o = 7'h4A;
      6'h12: ratio_o = 7'h4D;
      6'h13: ratio_o = 7'h50;
      6'h14: ratio_o = 7'h53;
      6'h15: ratio_o = 7'h56;
      6'h16: ratio_o = 7'h58;
      6'h17: ratio_o = 7'h5A;
      6'h18: ratio_o = 7'h5C;
      6'h19: ratio_o = 7'h5E;
      6'h1A: ratio_o = 7'h60;
      6'h1B: ratio_o = 7'h61;
      6'h1C: ratio_o = 7'h62;
      6'h1D: ratio_o = 7'h63;
      default: ratio_o = 7'h64;
    endcase
  end
endmodule

// ---- testbench/sif_indexer_sva.sv ----
// Assertion checker bound to the stepper indexer
`timescale 1ns/1ps
module sif_indexer_sva #(
  parameter STARTUP_CYC = 8
) (
  input logic       clk_sys_i,
  input logic       rst_i,
  input logic       step_select_bit0_i,
  input logic       step_select_bit1_i,
  input logic       step_select_bit2_i,
  input logic       thermal_shutdown_fault_i,
  input logic       overcurrent_fault_i,
  input logic       motor_supply_good_i,
  input logic       angle_reset_i,
  input logic       bias_enable_o,
  input logic       outputs_enable_o,
  input logic       startup_busy_o,
  input logic [6:0] ratio_a_o,
  input logic [6:0] ratio_b_o,
  input logic       home_angle_monitor_o,
  input logic       home_angle_monitor_oe_o,
  input logic       fault_monitor_o,
  input logic       fault_monitor_oe_o
);
  // --------------------------------------------------
  // Properties; windows of 6 to 8 cycles cover the pin synchronisers
  // --------------------------------------------------
  wire [2:0] sel = {step_select_bit0_i, step_select_bit1_i, step_select_bit2_i};
  wire       flt = thermal_shutdown_fault_i | overcurrent_fault_i;
  int        busy_run;
  always @(posedge clk_sys_i) busy_run <= (rst_i || !startup_busy_o) ? 0 : busy_run + 1;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  standby_off_a:
    assert property ((sel == 3'h0)[*6] |=> !bias_enable_o && !outputs_enable_o)
    else $error("awake in standby");
  standby_clear_a:
    assert property ((sel == 3'h0)[*6] |=> !fault_monitor_oe_o) else $error("fault kept");
  fault_latch_a:
    assert property ((flt && sel != 3'h0 && motor_supply_good_i)[*8] |=> fault_monitor_oe_o)
    else $error("fault not flagged");
  supply_clear_a:
    assert property ((!motor_supply_good_i)[*6] |=> !fault_monitor_oe_o) else $error("fault kept");
  od_low_a:
    assert property (!home_angle_monitor_o && !fault_monitor_o) else $error("drain high");
  home_hold_a:
    assert property ((angle_reset_i && sel != 3'h0)[*6] |=> home_angle_monitor_oe_o)
    else $error("home not flagged");
  init_ratio_a:
    assert property ((angle_reset_i && sel == 3'h7)[*6] |=> ratio_a_o == 7'h47 && ratio_b_o == 7'h47)
    else $error("bad initial ratio");
  quiet_bound_a:
    assert property (busy_run <= STARTUP_CYC + 2) else $error("quiet too long");
endmodule

bind sif_indexer sif_indexer_sva #(.STARTUP_CYC(STARTUP_CYC)) i_sva (.*);

// ---- testbench/sif_host_model.sv ----
// Host side model producing step clock pulses
`timescale 1ns/1ps
module sif_host_model (
  input  wire       clk_i,
  input  wire       start_i,
  input  wire [5:0] count_i,
  output reg        step_clk_o,
  output reg        busy_o
);
  // --------------------------------------------------
  // Pulses 4 high, 4 low, so the synchroniser never misses one
  // --------------------------------------------------
  reg [5:0] left = 6'h00;
  reg [2:0] phase = 3'h0;
  initial step_clk_o = 1'b0;
  initial busy_o = 1'b0;
  always @(negedge clk_i) begin
    if (start_i && !busy_o) begin
      left <= count_i;
      busy_o <= (count_i != 6'h00);
      phase <= 3'h0;
    end else if (busy_o) begin
      phase <= phase + 3'h1;
      if (phase == 3'h3) step_clk_o <= 1'b1;
      if (phase == 3'h7) begin
        step_clk_o <= 1'b0;
        left <= left - 6'h01;
        busy_o <= (left != 6'h01);
      end
    end
  end
endmodule

// ---- testbench/tb_sif_indexer.sv ----
// Self-checking testbench of the stepper indexer
`timescale 1ns/1ps
module tb_sif_indexer;
  typedef struct packed {logic [2:0] s; logic d; logic [5:0] n; logic [6:0] a, b; logic [1:0] g;} sif_row_t;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, step_clk_i, direction_select_i = 1'b1, angle_reset_i = 1'b1;
  logic thermal_shutdown_fault_i = 1'b0, overcurrent_fault_i = 1'b0, motor_supply_good_i = 1'b1;
  logic step_select_bit0_i, step_select_bit1_i, step_select_bit2_i, start = 1'b0, host_busy;
  logic bias_enable_o, outputs_enable_o, startup_busy_o, sign_a_o, sign_b_o;
  logic home_angle_monitor_o, home_angle_monitor_oe_o, fault_monitor_o, fault_monitor_oe_o;
  logic [6:0] ratio_a_o, ratio_b_o;
  logic [5:0] cnt = 6'h00;
  logic [2:0] sel = 3'h7;
  int num_errors = 0, checks_done = 0, cyc = 0;
  sif_row_t rows [9] = '{'{3'h7, 1'b1, 6'h01, 7'h43, 7'h4A, 2'h0}, '{3'h7, 1'b0, 6'h01, 7'h4A, 7'h43, 2'h0},
    '{3'h6, 1'b1, 6'h01, 7'h3F, 7'h4D, 2'h0}, '{3'h5, 1'b1, 6'h01, 7'h38, 7'h53, 2'h0},
    '{3'h3, 1'b1, 6'h01, 7'h26, 7'h64, 2'h0}, '{3'h2, 1'b1, 6'h02, 7'h64, 7'h64, 2'h2},
    '{3'h4, 1'b1, 6'h02, 7'h47, 7'h47, 2'h2}, '{3'h1, 1'b1, 6'h01, 7'h64, 7'h64, 2'h2},
    '{3'h7, 1'b0, 6'h11, 7'h64, 7'h05, 2'h1}};
  assign {step_select_bit0_i, step_select_bit1_i, step_select_bit2_i} = sel;
  always #2 clk_sys_i = ~clk_sys_i;
  sif_indexer #(.STARTUP_CYC(8)) i_dut (.*);
  sif_host_model i_host (.clk_i(clk_sys_i), .start_i(start), .count_i(cnt),
                         .step_clk_o(step_clk_i), .busy_o(host_busy));
  // --------------------------------------------------
  // Tasks
  // --------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic steps(input logic [5:0] n);
    int guard;
    guard = 0;
    cnt <= n;
    start <= 1'b1;
    idle(1);
    start <= 1'b0;
    idle(1);
    while (host_busy === 1'b1 && guard < 600) begin
      idle(1);
      guard++;
    end
    idle(8);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // --------------------------------------------------
  // Sequence; hold-offs after standby exit exceed the quiet period
  // --------------------------------------------------
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    idle(12);
    rst_i <= 1'b0;
    idle(20);
    foreach (rows[i]) begin
      sel <= rows[i].s;
      angle_reset_i <= 1'b1;
      direction_select_i <= rows[i].d;
      idle(12);
      chk("home_oe", home_angle_monitor_oe_o, 1'b1);
      chk("ratio_init", ratio_a_o, (rows[i].s inside {3'h1, 3'h2}) ? 7'h64 : 7'h47);
      angle_reset_i <= 1'b0;
      idle(8);
      steps(rows[i].n);
      chk("ratio_a", ratio_a_o, rows[i].a);
      chk("ratio_b", ratio_b_o, rows[i].b);
      chk("signs", {sign_a_o, sign_b_o}, rows[i].g);
      chk("home_oe", home_angle_monitor_oe_o, 1'b0);
    end
    $display("test stepping done");
    thermal_shutdown_fault_i <= 1'b1;
    idle(10);
    thermal_shutdown_fault_i <= 1'b0;
    idle(8);
    chk("fault_oe", fault_monitor_oe_o, 1'b1);
    sel <= 3'h0;
    idle(10);
    chk("fault_oe", fault_monitor_oe_o, 1'b0);
    chk("bias", bias_enable_o, 1'b0);
    chk("out_en", outputs_enable_o, 1'b0);
    sel <= 3'h7;
    idle(6);
    chk("busy", startup_busy_o, 1'b1);
    idle(14);
    chk("busy", startup_busy_o, 1'b0);
    chk("fault_oe", fault_monitor_oe_o, 1'b0);
    chk("bias", bias_enable_o, 1'b1);
    chk("out_en", outputs_enable_o, 1'b1);
    overcurrent_fault_i <= 1'b1;
    idle(10);
    overcurrent_fault_i <= 1'b0;
    idle(8);
    chk("fault_oe", fault_monitor_oe_o, 1'b1);
    motor_supply_good_i <= 1'b0;
    idle(8);
    motor_supply_good_i <= 1'b1;
    idle(8);
    chk("fault_oe", fault_monitor_oe_o, 1'b0);
    $display("test fault done");
    report_and_stop();
  end
endmodule
